// File: hdl/dic_pkg.sv
// package for the signal processor interrupt control block
// assumes one core clock shared by both processors
package dic_pkg;
    // external register indices on the processor register port
    localparam logic [2:0]  REG_IRQ_CONTROL   = 3'h4;
    localparam logic [2:0]  REG_CONVERTER     = 3'h5;
    localparam logic [2:0]  REG_ANALOG        = 3'h6;

    // interrupt control word fields
    localparam int          BIT_HOST_PEND     = 15;
    localparam int          BIT_ADC_PEND      = 14;
    localparam int          BIT_DAC_PEND      = 13;
    localparam int          BIT_MASK_HIGH     = 12;
    localparam int          BIT_MASK_MIDDLE   = 11;
    localparam int          BIT_MASK_LOW      = 10;
    localparam int          BIT_HOST_IPR      = 9;
    localparam int          BIT_GLOBAL_EN     = 8;
    localparam int          BIT_SEL_MSB       = 7;
    localparam int          BIT_SEL_LSB       = 5;
    localparam int          BIT_CLR_HOST      = 4;
    localparam int          BIT_CLR_ADC       = 3;
    localparam int          BIT_CLR_DAC       = 2;

    // converter data word fields
    localparam int          DAC_WIDTH         = 10;
    localparam int          ADC_WIDTH         = 8;
    localparam int          ADC_LSB           = 2;

    // analog config word fields
    localparam int          BIT_LOW_SRC       = 15;
    localparam int          BIT_FIXED_ONE     = 9;
    localparam int          BIT_DAC_RATE      = 8;
    localparam int          BIT_CONV_DONE     = 4;
    localparam int          BIT_ANALOG_RSVD   = 2;
    localparam logic [15:0] ANALOG_STORED     = 16'h81eb;
    localparam logic [15:0] ANALOG_RESET      = 16'h000a;

    localparam logic [15:0] IRQ_CONTROL_RESET = 16'h0000;

    // line codes: 2 high, 1 middle, 0 low
    localparam logic [1:0]  LINE_HIGH         = 2'h2;
    localparam logic [1:0]  LINE_MIDDLE       = 2'h1;
    localparam logic [1:0]  LINE_LOW          = 2'h0;

    // host instructions before the interprocessor request self-clears
    localparam logic [1:0]  HOST_CLEAR_INSTR  = 2'h3;

    typedef enum logic [0:0] {
        DIC_IDLE    = 1'b0,
        DIC_SERVICE = 1'b1
    } dic_state_e;
endpackage

// File: hdl/dic_arbiter.sv
// fixed priority pick among the three processor interrupt lines
// assumes requests are already masked and globally enabled
`timescale 1ns/1ps
module dic_arbiter
    import dic_pkg::*;
(
    input  wire logic [2:0] line_req,
    output wire logic       any_req,
    output wire logic [1:0] pick
);
    // high beats middle beats low
    assign any_req = |line_req;
    assign pick    = line_req[2] ? LINE_HIGH   :
                     line_req[1] ? LINE_MIDDLE : LINE_LOW;
endmodule

// File: hdl/dic_ipc_clear.sv
// counts control processor instructions after the request clear write
// assumes instr_step pulses once per retired host instruction
`timescale 1ns/1ps
module dic_ipc_clear
    import dic_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic start,
    input  wire logic instr_step,
    output wire logic expire
);
    logic       armed;
    logic [1:0] count;
    wire  logic last_step = armed && instr_step &&
                            (count == HOST_CLEAR_INSTR - 2'h1);

    assign expire = last_step;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            armed <= 1'b0;
            count <= 2'h0;
        end else if (start) begin
            armed <= 1'b1;
            count <= 2'h0;
        end else if (last_step) begin
            armed <= 1'b0;
            count <= 2'h0;
        end else if (armed && instr_step) begin
            count <= count + 2'h1;
        end
    end
endmodule

// File: hdl/dic_top.sv
// interrupt control, converter data and analog config registers
// assumes the processor register port and host strobes are synchronous
`timescale 1ns/1ps
module dic_top
    import dic_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic [2:0]           reg_index,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [15:0]          reg_wdata,
    output logic      [15:0]          reg_rdata,
    input  wire logic                 host_ctrl_set,
    input  wire logic                 host_ipr_clear_wr,
    input  wire logic                 host_instr_step,
    input  wire logic                 adc_valid,
    input  wire logic [ADC_WIDTH-1:0] adc_result,
    input  wire logic                 adc_conv_done,
    input  wire logic                 output_rate_timer,
    input  wire logic                 external_port_pin,
    input  wire logic                 isr_return,
    output logic                      irq_take,
    output logic      [1:0]           irq_line,
    output logic                      irq_busy,
    output logic                      host_interprocessor_request,
    output logic      [DAC_WIDTH-1:0] dac_data,
    output logic                      dac_load,
    output logic                      dac_rate_select,
    output logic      [7:0]           adc_config
);
    ////////////////////////////////////////////////////////////////////
    // stored state
    logic       host_request_pending;
    logic       adc_done_pending;
    logic       dac_timer_pending;
    logic       mask_line_high;
    logic       mask_line_middle;
    logic       mask_line_low;
    logic       global_irq_enable;
    logic [2:0] irq_select;
    logic [15:0] analog_config_word;
    dic_state_e state;
    logic       low_src_prev;

    ////////////////////////////////////////////////////////////////////
    // decode
    wire logic wr_ctl   = reg_wr && reg_index == REG_IRQ_CONTROL;
    wire logic wr_conv  = reg_wr && reg_index == REG_CONVERTER;
    wire logic wr_ana   = reg_wr && reg_index == REG_ANALOG;
    wire logic clr_host = wr_ctl && reg_wdata[BIT_CLR_HOST];
    wire logic clr_adc  = wr_ctl && reg_wdata[BIT_CLR_ADC];
    wire logic clr_dac  = wr_ctl && reg_wdata[BIT_CLR_DAC];

    // low source picked by the analog top bit; pin taken on its rising edge
    wire logic low_src  = analog_config_word[BIT_LOW_SRC]
                          ? external_port_pin
                          : output_rate_timer;
    wire logic low_event = low_src && !low_src_prev;

    // per-source line codes; reserved select codes fall back to 000
    logic [1:0] host_to;
    logic [1:0] adc_to;
    logic [1:0] dac_to;
    always_comb begin
        host_to = LINE_HIGH;
        adc_to  = LINE_MIDDLE;
        dac_to  = LINE_LOW;
        case (irq_select)
            3'h1: begin
                host_to = LINE_MIDDLE;
                adc_to  = LINE_HIGH;
            end
            3'h2: begin
                adc_to  = LINE_LOW;
                dac_to  = LINE_MIDDLE;
            end
            3'h3: begin
                host_to = LINE_MIDDLE;
                adc_to  = LINE_LOW;
                dac_to  = LINE_HIGH;
            end
            3'h4: begin
                host_to = LINE_LOW;
                adc_to  = LINE_HIGH;
                dac_to  = LINE_MIDDLE;
            end
            3'h5: begin
                host_to = LINE_LOW;
                adc_to  = LINE_MIDDLE;
                dac_to  = LINE_HIGH;
            end
            default: ;
        endcase
    end

    wire logic [2:0] line_raw;
    wire logic [2:0] line_mask = {mask_line_high, mask_line_middle,
                                  mask_line_low};
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_line
            assign line_raw[g] =
                (host_request_pending && host_to == 2'(g)) ||
                (adc_done_pending     && adc_to  == 2'(g)) ||
                (dac_timer_pending    && dac_to  == 2'(g));
        end
    endgenerate

    wire logic [2:0] line_req = global_irq_enable ? (line_raw & line_mask)
                                                  : 3'h0;
    wire logic       any_req;
    wire logic [1:0] pick;

    dic_arbiter u_arbiter (
        .line_req (line_req),
        .any_req  (any_req),
        .pick     (pick)
    );

    wire logic ipc_expire;

    dic_ipc_clear u_ipc_clear (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .start      (host_ipr_clear_wr),
        .instr_step (host_instr_step),
        .expire     (ipc_expire)
    );

    wire logic ipc_set = wr_ctl && reg_wdata[BIT_HOST_IPR];
    wire logic ipc_drop = (wr_ctl && !reg_wdata[BIT_HOST_IPR]) ||
                          ipc_expire;

    // read mux: virtual and host-held bits read zero
    wire logic [15:0] ctl_read = {host_request_pending, adc_done_pending,
                                  dac_timer_pending, mask_line_high,
                                  mask_line_middle, mask_line_low,
                                  1'b0, global_irq_enable, irq_select,
                                  5'h00};
    wire logic [15:0] conv_read = {6'h00, adc_result, 2'h0};
    wire logic [15:0] ana_read = (analog_config_word & ANALOG_STORED) |
                                 (16'h0001 << BIT_FIXED_ONE) |
                                 (16'(adc_conv_done) << BIT_CONV_DONE);
    wire logic [15:0] next_rdata =
        (reg_index == REG_IRQ_CONTROL) ? ctl_read  :
        (reg_index == REG_CONVERTER)   ? conv_read :
        (reg_index == REG_ANALOG)      ? ana_read  : 16'h0000;

    ////////////////////////////////////////////////////////////////////
    // pending flags: a set in the same cycle as its clear wins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            host_request_pending <= 1'b0;
            adc_done_pending     <= 1'b0;
            dac_timer_pending    <= 1'b0;
            low_src_prev         <= 1'b0;
        end else begin
            host_request_pending <= host_ctrl_set ||
                                    (host_request_pending && !clr_host);
            adc_done_pending     <= adc_valid ||
                                    (adc_done_pending && !clr_adc);
            dac_timer_pending    <= low_event ||
                                    (dac_timer_pending && !clr_dac);
            low_src_prev         <= low_src;
        end
    end

    // control fields
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mask_line_high    <= 1'b0;
            mask_line_middle  <= 1'b0;
            mask_line_low     <= 1'b0;
            global_irq_enable <= 1'b0;
            irq_select        <= 3'h0;
        end else if (wr_ctl) begin
            mask_line_high    <= reg_wdata[BIT_MASK_HIGH];
            mask_line_middle  <= reg_wdata[BIT_MASK_MIDDLE];
            mask_line_low     <= reg_wdata[BIT_MASK_LOW];
            global_irq_enable <= reg_wdata[BIT_GLOBAL_EN];
            irq_select        <= reg_wdata[BIT_SEL_MSB:BIT_SEL_LSB];
        end
    end

    // interprocessor request; a raise beats the timed drop
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            host_interprocessor_request <= 1'b0;
        end else if (ipc_set) begin
            host_interprocessor_request <= 1'b1;
        end else if (ipc_drop) begin
            host_interprocessor_request <= 1'b0;
        end
    end

    // converter data and analog config
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dac_data           <= '0;
            dac_load           <= 1'b0;
            analog_config_word <= ANALOG_RESET;
        end else begin
            dac_load <= wr_conv;
            if (wr_conv) begin
                dac_data <= reg_wdata[DAC_WIDTH-1:0];
            end
            if (wr_ana) begin
                analog_config_word <= reg_wdata & ANALOG_STORED;
            end
        end
    end

    assign dac_rate_select = analog_config_word[BIT_DAC_RATE];

    // registered so the port comes from a flop; conversion done lags a cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            adc_config <= ANALOG_RESET[7:0];
        end else begin
            adc_config <= ana_read[7:0];
        end
    end

    // service sequencing: one routine at a time, never nested
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state     <= DIC_IDLE;
            irq_take  <= 1'b0;
            irq_line  <= LINE_LOW;
            irq_busy  <= 1'b0;
            reg_rdata <= 16'h0000;
        end else begin
            irq_take <= 1'b0;
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
            case (state)
                DIC_IDLE: begin
                    if (any_req) begin
                        state    <= DIC_SERVICE;
                        irq_take <= 1'b1;
                        irq_line <= pick;
                        irq_busy <= 1'b1;
                    end
                end
                DIC_SERVICE: begin
                    if (isr_return) begin
                        state    <= DIC_IDLE;
                        irq_busy <= 1'b0;
                    end
                end
                default: state <= DIC_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // host steps seen since the last clear write; full count means idle
    logic [1:0] seen_steps;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            seen_steps <= HOST_CLEAR_INSTR;
        end else if (host_ipr_clear_wr) begin
            seen_steps <= 2'h0;
        end else if (host_instr_step && seen_steps != HOST_CLEAR_INSTR) begin
            seen_steps <= seen_steps + 2'h1;
        end
    end
    sequence s_third_step;
        seen_steps == HOST_CLEAR_INSTR - 2'h1 && host_instr_step &&
        !host_ipr_clear_wr && !ipc_set;
    endsequence

    property p_prio;
        state == DIC_IDLE && line_req[2] |=> irq_line == LINE_HIGH;
    endproperty
    a_prio: assert property (p_prio)
        else $error("high line not chosen first");

    property p_no_nest;
        state == DIC_SERVICE && !isr_return |=> !irq_take;
    endproperty
    a_no_nest: assert property (p_no_nest)
        else $error("interrupt taken during service");

    property p_host_set;
        host_ctrl_set |=> host_request_pending;
    endproperty
    a_host_set: assert property (p_host_set)
        else $error("host pending not set");

    property p_clear_adc;
        clr_adc && !adc_valid |=> !adc_done_pending;
    endproperty
    a_clear_adc: assert property (p_clear_adc)
        else $error("adc pending not cleared");

    property p_take_enabled;
        irq_take |-> $past(global_irq_enable) && $past(line_mask[pick]);
    endproperty
    a_take_enabled: assert property (p_take_enabled)
        else $error("interrupt taken while blocked");

    property p_ipc_raise;
        ipc_set |=> host_interprocessor_request;
    endproperty
    a_ipc_raise: assert property (p_ipc_raise)
        else $error("interprocessor request not raised");

    property p_ipc_drop;
        s_third_step |=> !host_interprocessor_request;
    endproperty
    a_ipc_drop: assert property (p_ipc_drop)
        else $error("interprocessor request not dropped");

    property p_read_zero;
        reg_rd && reg_index == REG_IRQ_CONTROL
            |=> reg_rdata[BIT_HOST_IPR] == 1'b0 && reg_rdata[4:2] == 3'h0;
    endproperty
    a_read_zero: assert property (p_read_zero)
        else $error("virtual bits read nonzero");

    property p_dac;
        wr_conv |=> dac_load && dac_data == $past(reg_wdata[9:0]);
    endproperty
    a_dac: assert property (p_dac)
        else $error("converter data not passed");
endmodule

// File: tb/dic_partner.sv
// host processor and converter model facing the interrupt block
// assumes the bench calls its tasks; every change lands at a falling edge
`timescale 1ns/1ps
module dic_partner
    import dic_pkg::*;
(
    input  wire logic                 ref_clk,
    output logic                      host_ctrl_set,
    output logic                      host_ipr_clear_wr,
    output logic                      host_instr_step,
    output logic                      adc_valid,
    output logic      [ADC_WIDTH-1:0] adc_result,
    output logic                      adc_conv_done,
    output logic                      output_rate_timer,
    output logic                      external_port_pin
);
    initial begin
        {host_ctrl_set, host_ipr_clear_wr, host_instr_step} = 3'h0;
        {adc_valid, adc_conv_done} = 2'h0;
        {output_rate_timer, external_port_pin} = 2'h0;
        adc_result = 8'h00;
    end

    // one-cycle strobe: 0 set, 1 clear write, 2 step, 3 adc, 4 timer, 5 pin
    task automatic strobe(input int which);
        @(negedge ref_clk);
        case (which)
            0: host_ctrl_set = 1'b1;
            1: host_ipr_clear_wr = 1'b1;
            2: host_instr_step = 1'b1;
            3: adc_valid = 1'b1;
            4: output_rate_timer = 1'b1;
            default: external_port_pin = 1'b1;
        endcase
        @(negedge ref_clk);
        {host_ctrl_set, host_ipr_clear_wr, host_instr_step} = 3'h0;
        {adc_valid, output_rate_timer, external_port_pin} = 3'h0;
    endtask

    task automatic adc_push(input logic [ADC_WIDTH-1:0] v);
        adc_result = v;
        adc_conv_done = 1'b1;
        strobe(3);
    endtask

    // routine ends with the clear write; the bench issues the third step
    task automatic host_isr_end();
        strobe(1);
        strobe(2);
        strobe(2);
    endtask
endmodule

// File: tb/testbench.sv
// self-checking bench for dic_top against a register-level model
// assumes dic_partner stands for the host processor and converters
`timescale 1ns/1ps
module testbench
    import dic_pkg::*;
;
    logic        ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        isr_return = 1'b0;
    logic [2:0]  reg_index = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic        irq_take, irq_busy, host_ipr_o, dac_load, dac_rate_select;
    logic [1:0]  irq_line;
    logic [9:0]  dac_data;
    logic [7:0]  adc_config;
    logic        hcs, hcw, his, adv, acd, ort, epp;
    logic [7:0]  adr;
    logic [2:0]  pend = 3'h0, mask = 3'h0, sel = 3'h0;
    logic        gen = 1'b0, ipr = 1'b0;
    logic [15:0] d, v;
    int          errors = 0, checks = 0;
    int          tbl[8] = '{1, 2, 0, 0, 2, 1, 1, 1};

    always #2 ref_clk = ~ref_clk;

    dic_partner partner_i (.ref_clk(ref_clk), .host_ctrl_set(hcs),
        .host_ipr_clear_wr(hcw), .host_instr_step(his), .adc_valid(adv),
        .adc_result(adr), .adc_conv_done(acd), .output_rate_timer(ort),
        .external_port_pin(epp));

    dic_top dic_top_i (.ref_clk(ref_clk), .rst(rst), .reg_index(reg_index),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .host_ctrl_set(hcs), .host_ipr_clear_wr(hcw),
        .host_instr_step(his), .adc_valid(adv), .adc_result(adr),
        .adc_conv_done(acd), .output_rate_timer(ort),
        .external_port_pin(epp), .isr_return(isr_return),
        .irq_take(irq_take), .irq_line(irq_line), .irq_busy(irq_busy),
        .host_interprocessor_request(host_ipr_o), .dac_data(dac_data),
        .dac_load(dac_load), .dac_rate_select(dac_rate_select),
        .adc_config(adc_config));

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [2:0] idx, input logic [15:0] dat);
        @(negedge ref_clk);
        {reg_wr, reg_index, reg_wdata} = {1'b1, idx, dat};
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [2:0] idx, output logic [15:0] dat);
        @(negedge ref_clk);
        {reg_rd, reg_index} = {1'b1, idx};
        @(negedge ref_clk);
        reg_rd = 1'b0;
        dat = reg_rdata;
    endtask

    // clear strobes sit in bits 4..2 of the written word
    task automatic wicr(input logic [2:0] clr);
        wr(REG_IRQ_CONTROL, {3'h0, mask, ipr, gen, sel, clr, 2'h0});
        pend = pend & ~clr;
    endtask

    task automatic chk_icr();
        rd(REG_IRQ_CONTROL, v);
        chk("icr", {pend, mask, 1'b0, gen, sel, 5'h00}, v);
    endtask

    task automatic wait_take(input logic [1:0] line);
        int i;
        for (i = 0; i < 20 && irq_take !== 1'b1; i++)
            @(negedge ref_clk);
        if (i == 20) begin
            errors++;
            $display("mismatch irq_take expected 1 seen %b", irq_take);
            test_done();
        end else begin
            chk("irq_line", line, irq_line);
            chk("irq_busy", 1'b1, irq_busy);
        end
    endtask

    task automatic no_take(input int n);
        int seen;
        seen = 0;
        repeat (n) begin
            @(negedge ref_clk);
            if (irq_take !== 1'b0)
                seen++;
        end
        chk("no irq_take", 0, seen[15:0]);
    endtask

    task automatic isr_done();
        @(negedge ref_clk);
        isr_return = 1'b1;
        @(negedge ref_clk);
        isr_return = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(53));
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        chk_icr();
        rd(REG_ANALOG, v);
        chk("analog reset", 16'h020a, v);
        rd(3'h7, v);
        chk("unmapped", 16'h0000, v);
        $display("test reset done");

        repeat (6) begin
            d = 16'($urandom);
            wr(REG_IRQ_CONTROL, d);
            {mask, ipr, gen, sel} = {d[12:10], d[9], d[8], d[7:5]};
            chk("host request", ipr, host_ipr_o);
            chk_icr();
            d = 16'($urandom);
            wr(REG_ANALOG, d);
            d = (d & ANALOG_STORED) | 16'h0200;
            rd(REG_ANALOG, v);
            chk("analog", d, v);
            chk("rate", d[8], dac_rate_select);
            chk("adc config", d[7:0], adc_config);
        end
        {mask, ipr, gen, sel} = 8'h00;
        wicr(3'h7);
        wr(REG_ANALOG, 16'h0000);
        $display("test registers done");

        d = 16'($urandom);
        wr(REG_CONVERTER, d);
        chk("dac_load", 1'b1, dac_load);
        chk("dac_data", d[9:0], dac_data);
        @(negedge ref_clk);
        chk("dac_load", 1'b0, dac_load);
        d = 16'($urandom);
        partner_i.adc_push(d[7:0]);
        pend[1] = 1'b1;
        rd(REG_CONVERTER, v);
        chk("adc data", {6'h00, d[7:0], 2'h0}, v);
        rd(REG_ANALOG, v);
        chk("conv done", 16'h0210, v);
        chk("adc config", 16'h0010, adc_config);
        $display("test converter done");

        partner_i.strobe(0);
        partner_i.strobe(4);
        pend = 3'h7;
        wr(REG_IRQ_CONTROL, 16'he000);
        chk_icr();
        wr(REG_ANALOG, 16'h8000);
        wicr(3'h1);
        partner_i.strobe(4);
        chk_icr();
        partner_i.strobe(5);
        pend[0] = 1'b1;
        chk_icr();
        wr(REG_ANALOG, 16'h0000);
        mask = 3'h7;
        wicr(3'h0);
        no_take(4);
        {gen, mask} = 4'h8;
        wicr(3'h0);
        no_take(4);
        mask = 3'h7;
        wicr(3'h0);
        wait_take(LINE_HIGH);
        wicr(3'h4);
        no_take(6);
        isr_done();
        wait_take(LINE_MIDDLE);
        wicr(3'h2);
        isr_done();
        wait_take(LINE_LOW);
        wicr(3'h1);
        isr_done();
        no_take(4);
        chk("irq_busy", 1'b0, irq_busy);
        chk_icr();
        $display("test priority done");

        for (int s = 0; s < 8; s++) begin
            sel = s[2:0];
            wicr(3'h0);
            partner_i.adc_push(8'($urandom));
            wait_take(tbl[s][1:0]);
            wicr(3'h2);
            isr_done();
        end
        $display("test selection done");

        {gen, ipr} = 2'b01;
        wicr(3'h0);
        chk("host request", 1'b1, host_ipr_o);
        ipr = 1'b0;
        wicr(3'h0);
        chk("host request", 1'b0, host_ipr_o);
        ipr = 1'b1;
        wicr(3'h0);
        chk_icr();
        partner_i.host_isr_end();
        chk("host request", 1'b1, host_ipr_o);
        partner_i.strobe(2);
        chk("host request", 1'b0, host_ipr_o);
        $display("test interprocessor done");
        test_done();
    end
endmodule
